//--- src/adc_conversion_control.sv
// Behaviour
// - Produce an unsigned eight-bit result from the sampled analog input.
// - Only one conversion clock source: internal oscillator divided by four.
// - Every conversion lasts thirteen conversion bit periods.
// - The divisor sets only the bit period length, never the period count.
// - With the fixed divisor a conversion ends after thirteen instruction cycles.
// - Reference is always the supply rail; no external reference selectable.
// - Any reset sets the analog pin select field to binary 11.
// - Pins selected as analog lose their digital output function.
// - Analog pin select acts on pins regardless of converter enable.
// - Channel select routes the chosen source to the sampling circuit.
// - The absolute reference channel is usable whatever the analog pin selection.
// - Sleep entry discards the converter's channel selection.
// - Start/done set starts; cleared at completion; manual clear aborts, partial result once a bit is decided.
// - Setting start/done has no effect while converter enable is clear.
// - Sleep clears start/done and enable, stops conversion, channel becomes 11.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module adc_conversion_control
(
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_rst_n,
    input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [adc_ctrl_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                              i_wr,
    input  wire logic                              i_rd,
    output logic      [adc_ctrl_pkg::DATA_W-1:0]   o_rdata,
    input  wire logic                              i_sleep_enter,
    input  wire logic                              i_cmp_high,
    output logic      [7:0]                        o_dac_code,
    output logic                                   o_sample_hold,
    output logic      [1:0]                        o_channel_route,
    output logic                                   o_route_enable,
    output logic      [1:0]                        o_pin_digital_disable,
    output logic                                   o_converter_powered,
    output logic                                   o_ref_supply,
    output logic                                   o_busy
);
    import adc_ctrl_pkg::*;

    sar_if sar ();

    logic [1:0] analog_pin_select;
    logic [1:0] channel_select;
    logic       converter_enable;
    logic       start_done;
    logic [7:0] conversion_result;
    logic [1:0] prescale;
    logic       next_start_done;
    logic [7:0] next_rdata;

    // Register decode.
    wire        wr_control   = i_wr & (i_addr == ADDR_CONTROL);
    wire        rd_control   = i_rd & (i_addr == ADDR_CONTROL);
    wire        rd_result    = i_rd & (i_addr == ADDR_RESULT);
    wire        w_enable     = i_wdata[POS_ENABLE];
    wire        w_start_done = i_wdata[POS_START_DONE];
    wire [1:0]  w_channel    = i_wdata[POS_CHANNEL_HI:POS_CHANNEL_LO];
    wire [1:0]  w_analog     = i_wdata[POS_ANALOG_HI:POS_ANALOG_LO];

    // A start needs the enable already set; a write that sets both only powers up.
    // A write that clears the enable, or a sleep entry in the same cycle, refuses it,
    // so the engine can never run while the converter is powered down.
    wire        start_req    = wr_control & w_start_done & w_enable & converter_enable &
                               ~start_done & ~i_sleep_enter;
    wire        sw_abort     = wr_control & start_done & (~w_start_done | ~w_enable);
    wire        conv_done    = sar.done;

    // Completion in the same cycle as a clearing write still counts as completion.
    wire        abort_req    = start_done & ~conv_done & (i_sleep_enter | sw_abort);
    wire        keep_partial = abort_req & sar.partial_ok;

    wire [7:0]  control_view;
    assign control_view[POS_ENABLE]                    = converter_enable;
    assign control_view[POS_START_DONE]                = start_done;
    assign control_view[POS_CHANNEL_HI:POS_CHANNEL_LO] = channel_select;
    assign control_view[5:4]                           = 2'h0;
    assign control_view[POS_ANALOG_HI:POS_ANALOG_LO]   = analog_pin_select;

    assign next_rdata = rd_control ? control_view :
                        rd_result  ? conversion_result : 8'h00;

    // The divider restarts with each conversion so that every one takes exactly
    // thirteen full bit periods, whatever phase the divider was in before.
    wire        bit_tick     = sar.busy & (prescale == PRESCALE_LAST);

    assign sar.tick     = bit_tick;
    assign sar.start    = start_req;
    assign sar.abort    = abort_req;
    assign sar.cmp_high = i_cmp_high;

    sar_engine u_sar_engine
    (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .sar       (sar)
    );

    // Pin channels reach the sampler only when their pin is in analog mode;
    // the absolute reference is always reachable. Code 11 routes nothing.
    wire        pin_channel  = (channel_select == CHAN_INPUT_ZERO) |
                               (channel_select == CHAN_INPUT_ONE);
    wire        pin_analog   = analog_pin_select[channel_select[0]];

    assign o_channel_route       = channel_select;
    assign o_route_enable        = (pin_channel & pin_analog) |
                                   (channel_select == CHAN_ABS_REF);
    assign o_pin_digital_disable = analog_pin_select;
    assign o_converter_powered   = converter_enable;
    assign o_ref_supply          = 1'b1;
    assign o_sample_hold         = sar.sampling;
    assign o_dac_code            = sar.code;
    assign o_busy                = start_done;

    always_comb
    begin
        next_start_done = start_done;
        if (i_sleep_enter)
        begin
            next_start_done = 1'b0;
        end
        else if (start_req)
        begin
            next_start_done = 1'b1;
        end
        else if (conv_done)
        begin
            next_start_done = 1'b0;
        end
        else if (sw_abort)
        begin
            next_start_done = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prescale <= 2'h0;
        end
        else if (start_req)
        begin
            prescale <= 2'h0;
        end
        else
        begin
            prescale <= prescale + 2'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            start_done <= 1'b0;
        end
        else
        begin
            start_done <= next_start_done;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            converter_enable <= 1'b0;
        end
        else if (i_sleep_enter)
        begin
            converter_enable <= 1'b0;
        end
        else if (wr_control)
        begin
            converter_enable <= w_enable;
        end
    end

    // Sleep leaves the pin selection alone; only a reset restores it.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            analog_pin_select <= RST_ANALOG_PINS;
        end
        else if (wr_control)
        begin
            analog_pin_select <= w_analog;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            channel_select <= RST_CHANNEL;
        end
        else if (i_sleep_enter)
        begin
            channel_select <= SLEEP_CHANNEL;
        end
        else if (wr_control)
        begin
            channel_select <= w_channel;
        end
    end

    // An abort after the first bit decision keeps the decided bits, the rest read zero; an earlier abort leaves the result as it was.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            conversion_result <= RST_RESULT;
        end
        else if (conv_done)
        begin
            conversion_result <= sar.value;
        end
        else if (keep_partial)
        begin
            conversion_result <= sar.value;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 8'h00;
        end
        else
        begin
            o_rdata <= next_rdata;
        end
    end
endmodule : adc_conversion_control

//--- src/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    localparam int unsigned ADDR_W          = 4;
    localparam int unsigned DATA_W          = 8;

    localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
    localparam logic [3:0]  ADDR_RESULT     = 4'h1;

    localparam int unsigned POS_ENABLE      = 0;
    localparam int unsigned POS_START_DONE  = 1;
    localparam int unsigned POS_CHANNEL_LO  = 2;
    localparam int unsigned POS_CHANNEL_HI  = 3;
    localparam int unsigned POS_ANALOG_LO   = 6;
    localparam int unsigned POS_ANALOG_HI   = 7;

    localparam logic [1:0]  RST_ANALOG_PINS = 2'h3;
    localparam logic [1:0]  RST_CHANNEL     = 2'h3;
    localparam logic [1:0]  SLEEP_CHANNEL   = 2'h3;
    localparam logic [7:0]  RST_RESULT      = 8'h00;

    localparam logic [1:0]  CHAN_INPUT_ZERO = 2'h0;
    localparam logic [1:0]  CHAN_INPUT_ONE  = 2'h1;
    localparam logic [1:0]  CHAN_ABS_REF    = 2'h2;

    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned OSC_DIVISOR     = 4;
    localparam int unsigned BIT_PERIOD_NS   = OSC_DIVISOR * CLK_PERIOD_NS;
    localparam int unsigned BIT_PERIOD_CYC  = BIT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned PERIODS_PER_CONV = 13;
    localparam int unsigned CONV_CYCLES     = PERIODS_PER_CONV * BIT_PERIOD_CYC;

    localparam logic [1:0]  PRESCALE_LAST   = 2'(BIT_PERIOD_CYC - 1);
    localparam logic [3:0]  PERIOD_SAMPLE   = 4'h0;
    localparam logic [3:0]  PERIOD_LAST_BIT = 4'h8;
    localparam logic [3:0]  PERIOD_LAST     = 4'(PERIODS_PER_CONV - 1);
    localparam logic [7:0]  PROBE_FIRST     = 8'h80;

    typedef enum logic [1:0]
    {
        SAR_IDLE    = 2'b00,
        SAR_SAMPLE  = 2'b01,
        SAR_CONVERT = 2'b10,
        SAR_SETTLE  = 2'b11
    } sar_state_e;

endpackage : adc_ctrl_pkg

//--- src/sar_if.sv
`timescale 1ns/1ps
interface sar_if;
    logic       tick;
    logic       start;
    logic       abort;
    logic       cmp_high;
    logic       busy;
    logic       sampling;
    logic       done;
    logic       partial_ok;
    logic [7:0] code;
    logic [7:0] value;

    modport ctrl
    (
        output tick, start, abort, cmp_high,
        input  busy, sampling, done, partial_ok, code, value
    );

    modport engine
    (
        input  tick, start, abort, cmp_high,
        output busy, sampling, done, partial_ok, code, value
    );
endinterface : sar_if

//--- src/sar_engine.sv
`timescale 1ns/1ps
module sar_engine
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    sar_if.engine     sar
);
    import adc_ctrl_pkg::*;

    sar_state_e state;
    sar_state_e next_state;
    logic [3:0] period;
    logic [7:0] trial;
    logic [7:0] probe;
    logic [7:0] next_trial;
    wire        last_period = (period == PERIOD_LAST);

    // The probe bit marks the bit under test; bits at and below it are not yet decided.
    assign next_trial     = (sar.cmp_high ? trial : (trial & ~probe)) | (probe >> 1);
    assign sar.busy       = (state != SAR_IDLE);
    assign sar.sampling   = (state == SAR_SAMPLE);
    assign sar.done       = sar.tick & (state == SAR_SETTLE) & last_period;
    assign sar.value      = trial & ~probe;
    assign sar.partial_ok = (probe != PROBE_FIRST);
    assign sar.code       = trial;

    always_comb
    begin
        next_state = state;
        case (state)
            SAR_IDLE:    next_state = SAR_IDLE;
            SAR_SAMPLE:  if (period == PERIOD_SAMPLE) next_state = SAR_CONVERT;
            SAR_CONVERT: if (period == PERIOD_LAST_BIT) next_state = SAR_SETTLE;
            SAR_SETTLE:  if (last_period) next_state = SAR_IDLE;
            default:     next_state = SAR_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state  <= SAR_IDLE;
            period <= 4'h0;
            trial  <= 8'h00;
            probe  <= PROBE_FIRST;
        end
        else if (sar.start)
        begin
            state  <= SAR_SAMPLE;
            period <= PERIOD_SAMPLE;
            trial  <= PROBE_FIRST;
            probe  <= PROBE_FIRST;
        end
        else if (sar.abort)
        begin
            state  <= SAR_IDLE;
        end
        else if (sar.tick && sar.busy)
        begin
            state  <= next_state;
            period <= period + 4'h1;
            if (state == SAR_CONVERT)
            begin
                trial <= next_trial;
                probe <= probe >> 1;
            end
        end
    end
endmodule : sar_engine

//--- tb/adc_conversion_control_chk.sv
`timescale 1ns/1ps
module adc_conversion_control_chk
(
    input  wire logic                            i_clk_sys,
    input  wire logic                            i_rst_n,
    input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [adc_ctrl_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                            i_wr,
    input  wire logic                            i_sleep_enter,
    input  wire logic                            o_sample_hold,
    input  wire logic [1:0]                      o_channel_route,
    input  wire logic                            o_route_enable,
    input  wire logic [1:0]                      o_pin_digital_disable,
    input  wire logic                            o_converter_powered,
    input  wire logic                            o_ref_supply,
    input  wire logic                            o_busy
);
    import adc_ctrl_pkg::*;
    logic [7:0] busy_cnt;
    wire        ctrl_wr = i_wr && (i_addr == ADDR_CONTROL);
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            busy_cnt <= 8'h00;
        else
            busy_cnt <= o_busy ? busy_cnt + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    ref_on_supply_a: assert property (o_ref_supply)
        else $error("reference not on supply");
    busy_needs_enable_a: assert property (o_busy |-> o_converter_powered)
        else $error("busy while converter disabled");
    start_refused_a: assert property (ctrl_wr && i_wdata[1] && !o_converter_powered
        && !o_busy |=> !o_busy) else $error("start taken while disabled");
    start_taken_a: assert property (ctrl_wr && i_wdata[1:0] == 2'h3 && o_converter_powered
        && !o_busy && !i_sleep_enter |=> o_busy) else $error("start not taken");
    conv_length_a: assert property (busy_cnt <= 8'(CONV_CYCLES))
        else $error("conversion too long");
    sample_period_a: assert property ($rose(o_busy) |-> (o_sample_hold || !o_busy)[*4]
        ##1 !o_sample_hold) else $error("sampling period not one bit period");
    pins_follow_a: assert property (ctrl_wr |=> o_pin_digital_disable == $past(i_wdata[7:6]))
        else $error("pin disable does not follow write");
    sleep_clears_a: assert property (i_sleep_enter |=> !o_busy && !o_converter_powered
        && o_channel_route == SLEEP_CHANNEL) else $error("sleep entry did not clear");
    sleep_keeps_pins_a: assert property (i_sleep_enter |=> $stable(o_pin_digital_disable))
        else $error("sleep changed pin select");
    route_gate_a: assert property (o_route_enable == (o_channel_route == CHAN_ABS_REF
        || (!o_channel_route[1] && o_pin_digital_disable[o_channel_route[0]])))
        else $error("route enable wrong");
endmodule : adc_conversion_control_chk

bind adc_conversion_control adc_conversion_control_chk u_chk
(
    .i_clk_sys             (i_clk_sys),
    .i_rst_n               (i_rst_n),
    .i_addr                (i_addr),
    .i_wdata               (i_wdata),
    .i_wr                  (i_wr),
    .i_sleep_enter         (i_sleep_enter),
    .o_sample_hold         (o_sample_hold),
    .o_channel_route       (o_channel_route),
    .o_route_enable        (o_route_enable),
    .o_pin_digital_disable (o_pin_digital_disable),
    .o_converter_powered   (o_converter_powered),
    .o_ref_supply          (o_ref_supply),
    .o_busy                (o_busy)
);

//--- tb/adc_conversion_control_tb.sv
`timescale 1ns/1ps
module adc_conversion_control_tb;
    import adc_ctrl_pkg::*;
    logic       i_clk_sys, i_rst_n, i_wr, i_rd, i_sleep_enter, i_cmp_high;
    logic       o_sample_hold, o_route_enable, o_converter_powered, o_ref_supply, o_busy;
    logic [1:0] o_channel_route, o_pin_digital_disable;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, o_dac_code, target;
    int         miscompares = 0;
    int         samples_checked = 0;

    adc_conversion_control u_dut
    (
        .i_clk_sys             (i_clk_sys),
        .i_rst_n               (i_rst_n),
        .i_addr                (i_addr),
        .i_wdata               (i_wdata),
        .i_wr                  (i_wr),
        .i_rd                  (i_rd),
        .o_rdata               (o_rdata),
        .i_sleep_enter         (i_sleep_enter),
        .i_cmp_high            (i_cmp_high),
        .o_dac_code            (o_dac_code),
        .o_sample_hold         (o_sample_hold),
        .o_channel_route       (o_channel_route),
        .o_route_enable        (o_route_enable),
        .o_pin_digital_disable (o_pin_digital_disable),
        .o_converter_powered   (o_converter_powered),
        .o_ref_supply          (o_ref_supply),
        .o_busy                (o_busy)
    );

    initial
    begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    // Comparator stand-in: the trial code holds for a whole bit period, so one cycle lag is safe.
    always @(posedge i_clk_sys) i_cmp_high <= (target >= o_dac_code);

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        #1;
        check(name, o_rdata, exp);
    endtask : rd

    task automatic reset_values;
        rd("ctrl_rst", ADDR_CONTROL, 8'hcc);
        rd("res_rst", ADDR_RESULT, RST_RESULT);
        check("pins_rst", o_pin_digital_disable, 8'h03);
        check("ref", o_ref_supply, 8'h01);
    endtask : reset_values

    task automatic start_refused;
        wr(ADDR_CONTROL, 8'h82);
        rd("ctrl_ref", ADDR_CONTROL, 8'h80);
        check("pins_off", o_pin_digital_disable, 8'h02);
    endtask : start_refused

    task automatic convert(input logic [1:0] ch, input logic [1:0] pins, input logic [7:0] t,
                           input logic en);
        int n;
        target = t;
        wr(ADDR_CONTROL, {pins, 2'b00, ch, 2'b01});
        wr(ADDR_CONTROL, {pins, 2'b00, ch, 2'b11});
        @(posedge i_clk_sys);
        #1;
        check("dac_first", o_dac_code, PROBE_FIRST);
        check("route", o_channel_route, ch);
        check("route_en", o_route_enable, en);
        check("pins", o_pin_digital_disable, pins);
        n = 1;
        while (o_busy === 1'b1 && n < 200)
        begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        check("conv_len", 8'(n), 8'(CONV_CYCLES));
        rd("result", ADDR_RESULT, t);
        rd("ctrl_done", ADDR_CONTROL, {pins, 2'b00, ch, 2'b01});
        wr(ADDR_CONTROL, {pins, 2'b00, ch, 2'b00});
        #1;
        check("powered_off", o_converter_powered, 8'h00);
    endtask : convert

    task automatic abort_cases;
        target = 8'h3c;
        wr(ADDR_CONTROL, 8'h41);
        wr(ADDR_CONTROL, 8'h43);
        wr(ADDR_CONTROL, 8'h41);
        #1;
        check("busy_abort", o_busy, 8'h00);
        rd("res_abort", ADDR_RESULT, 8'hff);
        wr(ADDR_CONTROL, 8'h43);
        @(posedge i_clk_sys);
        i_sleep_enter <= 1'b1;
        @(posedge i_clk_sys);
        i_sleep_enter <= 1'b0;
        #1;
        check("busy_sleep", o_busy, 8'h00);
        rd("ctrl_sleep", ADDR_CONTROL, 8'h4c);
        rd("res_sleep", ADDR_RESULT, 8'hff);
        // Abort after three bit decisions: only the decided top bits of the target remain.
        wr(ADDR_CONTROL, 8'h41);
        wr(ADDR_CONTROL, 8'h43);
        repeat (16) @(posedge i_clk_sys);
        wr(ADDR_CONTROL, 8'h41);
        #1;
        check("busy_part", o_busy, 8'h00);
        rd("res_part", ADDR_RESULT, 8'h20);
    endtask : abort_cases

    task automatic reset_again;
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rd("ctrl_rst2", ADDR_CONTROL, 8'hcc);
    endtask : reset_again

    task automatic results;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    initial
    begin
        repeat (5000) @(posedge i_clk_sys);
        miscompares++;
        results();
    end

    initial
    begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_sleep_enter = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        target = 8'h00;
        repeat (20) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        reset_values();
        start_refused();
        convert(CHAN_ABS_REF, 2'b00, 8'h00, 1'b1);
        convert(CHAN_INPUT_ZERO, 2'b11, 8'ha5, 1'b1);
        convert(CHAN_INPUT_ONE, 2'b01, 8'hff, 1'b0);
        abort_cases();
        reset_again();
        results();
    end
endmodule : adc_conversion_control_tb
